// ---- hdl/brm_pkg.sv ----
// Constants, types and decode function shared by the rate multiplier files.
//
// Operation
// - Counting runs only while clear, rate inhibit and enable inputs are all low.
// - A six-bit counter repeats its full cycle every 64 clocks while enabled.
// - Exactly M pulses appear per 64 enabled clocks, M weighted 32 down to 1.
// - A high rate inhibit blocks the rate decoding, so no rate pulses appear.
// - With rate value zero the complementary pulse output stays high all cycle.
// - Clear, inhibit and gate high give product low, pulse high, carry high.
// - A low product gate holds the product output high; pulse output unaffected.
// - With decoding inhibited, the product output is the gate input inverted.
// - Rate changes are accepted live; each clock decodes the present rate value.
// - The carry output pulses once per full 64-clock counter cycle.
package brm_pkg;

   localparam int          CNT_W         = 6;
   localparam int          CYCLE_LEN     = 64;
   localparam int          CLK_PERIOD_NS = 50;
   localparam logic [5:0]  CNT_RESET     = 6'h00;
   localparam logic [5:0]  CNT_LAST      = 6'h3f;
   localparam logic [5:0]  CNT_STEP      = 6'h01;
   localparam logic        PULSE_N_RESET = 1'h1;
   localparam logic        CARRY_N_RESET = 1'h1;
   localparam logic        PRODUCT_RESET = 1'h0;

   typedef logic [CNT_W-1:0] brm_count_t;

   // Rate bit k (weight 2^k) fires when the counter's lowest set bit sits at position 5-k,
   // so the slots of different bits never overlap and bit k fires 2^k times per cycle.
   function automatic logic rate_hit(input brm_count_t cnt, input brm_count_t rate);
      logic hit;
      hit = 1'b0;
      for (int k = 0; k < CNT_W; k++) begin
         if (rate[k] && cnt[CNT_W-1-k] && ((cnt & ((brm_count_t'(1) << (CNT_W-1-k)) - CNT_STEP)) == CNT_RESET)) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

endpackage

// ---- hdl/brm_cnt_if.sv ----
// Interface carrying the counter state between the counter and the rate decoder.
interface brm_cnt_if;
   brm_pkg::brm_count_t count_val;
   logic                count_run;

   modport ctr (input count_run, output count_val);
   modport dec (input count_run, input count_val);
endinterface

// ---- hdl/brm_counter.sv ----
// Six-bit cycle counter with asynchronous clear.
module brm_counter (
   // Clock and resets.
   input  wire logic   sys_clk,
   input  wire logic   resetn,
   input  wire logic   clear,
   // Counter state.
   brm_cnt_if.ctr      cnt_bus
);

   brm_pkg::brm_count_t cnt_reg;
   brm_pkg::brm_count_t cnt_next;

   // Advance by one when running; the six-bit width wraps 63 to 0 every 64 clocks.
   always_comb begin
      cnt_next = cnt_reg;
      if (cnt_bus.count_run) begin
         cnt_next = cnt_reg + brm_pkg::CNT_STEP;
      end
   end

   // Clear acts without the clock and holds the counter at zero while high.
   always_ff @(posedge sys_clk or negedge resetn or posedge clear) begin
      if (!resetn || clear) begin
         cnt_reg <= brm_pkg::CNT_RESET;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign cnt_bus.count_val = cnt_reg;

endmodule

// ---- hdl/brm_decoder.sv ----
// Rate decoder: flags the counter states that produce a rate pulse.
module brm_decoder (
   // Counter state.
   brm_cnt_if.dec               cnt_bus,
   // Rate selection and result.
   input  wire logic [5:0]      rate_val,
   output logic                 rate_pulse
);

   // Decode the rate value presented in this very cycle against the counter.
   always_comb begin
      rate_pulse = cnt_bus.count_run && brm_pkg::rate_hit(cnt_bus.count_val, rate_val);
   end

endmodule

// ---- hdl/brm_top.sv ----
// Top level of the six-bit binary rate multiplier.
module brm_top (
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // Counter control.
   input  wire logic        clear,
   input  wire logic        count_en_n,
   input  wire logic        rate_inhibit,
   // Rate value, rate_val[5] is rate_bit_msb and rate_val[0] is rate_bit_lsb.
   input  wire logic [5:0]  rate_val,
   // Product output gate (unity/cascade).
   input  wire logic        cascade_gate,
   // Outputs.
   output logic             product_out,
   output logic             pulse_n,
   output logic             carry_n
);

   brm_cnt_if cnt_bus ();

   logic run;
   logic rate_pulse;
   logic pulse_n_reg;
   logic pulse_n_next;
   logic carry_n_reg;
   logic carry_n_next;
   logic product_reg;
   logic product_next;

   // Counting is enabled only with all three control inputs low.
   assign run               = !clear && !count_en_n && !rate_inhibit;
   assign cnt_bus.count_run = run;

   brm_counter u_counter (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .clear   (clear),
      .cnt_bus (cnt_bus)
   );

   brm_decoder u_decoder (
      .cnt_bus    (cnt_bus),
      .rate_val   (rate_val),
      .rate_pulse (rate_pulse)
   );

   // Output gating: pulse low on a rate slot, carry low on the last state, product as NAND.
   always_comb begin
      pulse_n_next = !(rate_pulse && !rate_inhibit);
      carry_n_next = !(run && (cnt_bus.count_val == brm_pkg::CNT_LAST));
      product_next = !(pulse_n_next && cascade_gate);
   end

   // Output registers, so every output comes straight from a flip-flop.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pulse_n_reg <= brm_pkg::PULSE_N_RESET;
         carry_n_reg <= brm_pkg::CARRY_N_RESET;
         product_reg <= brm_pkg::PRODUCT_RESET;
      end else begin
         pulse_n_reg <= pulse_n_next;
         carry_n_reg <= carry_n_next;
         product_reg <= product_next;
      end
   end

   assign pulse_n     = pulse_n_reg;
   assign carry_n     = carry_n_reg;
   assign product_out = product_reg;

   // Checks on counter and output behaviour.
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   sequence s_last_running;
      run && (cnt_bus.count_val == brm_pkg::CNT_LAST);
   endsequence

   sequence s_wrapped;
      (cnt_bus.count_val == brm_pkg::CNT_RESET) && !carry_n;
   endsequence

   chk_clear_zero: assert property (clear |-> cnt_bus.count_val == brm_pkg::CNT_RESET)
      else $error("Counter not zero while clear is high.");
   chk_count_hold: assert property (!run && !clear |=> clear || cnt_bus.count_val == $past(cnt_bus.count_val))
      else $error("Counter moved while counting was disabled.");
   // A clear that arrives between the two edges zeroes the counter at once, so it excuses the step.
   chk_count_step: assert property (run |=> clear || cnt_bus.count_val == $past(cnt_bus.count_val) + brm_pkg::CNT_STEP)
      else $error("Counter did not advance by one.");
   chk_edge_sample: assert property (run && !clear ##1 !run && !clear |=> clear || $stable(cnt_bus.count_val))
      else $error("Counter ignored the enable sampled at the edge.");
   chk_inhibit_quiet: assert property (rate_inhibit |=> pulse_n)
      else $error("Rate pulse seen while decoding is inhibited.");
   chk_zero_rate: assert property (rate_val == 6'h00 |=> pulse_n)
      else $error("Pulse output dropped with rate value zero.");
   chk_live_rate: assert property (run && brm_pkg::rate_hit(cnt_bus.count_val, rate_val) |=> !pulse_n)
      else $error("Decoded rate slot produced no pulse.");
   chk_no_stray: assert property (run && !brm_pkg::rate_hit(cnt_bus.count_val, rate_val) |=> pulse_n)
      else $error("Pulse produced outside a decoded rate slot.");
   chk_clear_levels: assert property (clear && rate_inhibit && cascade_gate |=> !product_out && pulse_n && carry_n)
      else $error("Outputs wrong under clear.");
   chk_gate_low: assert property (!cascade_gate |=> product_out)
      else $error("Product not held high by a low gate.");
   chk_unity_pass: assert property (rate_inhibit |=> product_out == !$past(cascade_gate))
      else $error("Product is not the inverted gate under inhibit.");
   chk_nand_out: assert property (1'b1 |=> product_out == !(pulse_n && $past(cascade_gate)))
      else $error("Product is not the NAND of pulse and gate.");
   chk_carry_wrap: assert property (s_last_running |=> s_wrapped)
      else $error("Carry missing at counter wrap.");
   chk_carry_only: assert property (!carry_n |-> $past(run && (cnt_bus.count_val == brm_pkg::CNT_LAST)))
      else $error("Carry pulsed outside the last counter state.");

endmodule

// ---- dv/brm_gate_model.sv ----
// Far-side model that drives the product gate input of the rate multiplier.
module brm_gate_model (
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // Gate mode and gate output.
   input  wire logic [1:0]  gate_mode,
   output logic             cascade_gate,
   // Carry of a preceding stage.
   output logic             feed_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       toggle_reg;
   logic [5:0] feed_cnt_reg;
   // A free-running six-bit count stands in for the counter of the preceding stage.
   always_ff @(negedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         feed_cnt_reg <= 6'h00;
      end else begin
         feed_cnt_reg <= feed_cnt_reg + 6'h01;
      end
   end
   // The preceding stage's carry is low for one clock in every 64 and feeds enable and inhibit.
   assign feed_n = (feed_cnt_reg != 6'h3f);
   // A toggle flop stands in for the clock that is fed back to the gate in unity use.
   always_ff @(negedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         toggle_reg <= 1'h0;
      end else begin
         toggle_reg <= ~toggle_reg;
      end
   end
   // Mode 0 holds the gate high, mode 1 holds it low, and mode 2 follows the toggle.
   assign cascade_gate = (gate_mode == 2'h0) ? 1'h1 : (gate_mode == 2'h1) ? 1'h0 : toggle_reg;
endmodule

// ---- dv/binary_rate_multiplier_6bit_tb_top.sv ----
// Self-checking bench for the six-bit rate multiplier.
module binary_rate_multiplier_6bit_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       sys_clk = 1'h0, resetn = 1'h0, clear = 1'h0, count_en_n = 1'h0, rate_inhibit = 1'h1;
   logic [5:0] rate_val = 6'h00;
   logic [1:0] gate_mode = 2'h0;
   logic       cascade_gate, product_out, pulse_n, carry_n, feed_n;
   logic       chain = 1'h0;
   logic [5:0] rates [9] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h3f, 6'h28};
   int         err_total = 0, total_checks = 0, cyc = 0, tn = 0;
   // In chained use the preceding stage's carry drives both enable and rate inhibit.
   brm_top u_dut (.sys_clk(sys_clk), .resetn(resetn), .clear(clear), .count_en_n(chain ? feed_n : count_en_n),
      .rate_inhibit(chain ? feed_n : rate_inhibit), .rate_val(rate_val), .cascade_gate(cascade_gate),
      .product_out(product_out), .pulse_n(pulse_n), .carry_n(carry_n));
   brm_gate_model u_gate (.sys_clk(sys_clk), .resetn(resetn), .gate_mode(gate_mode), .cascade_gate(cascade_gate),
      .feed_n(feed_n));
   // The clock has a 50 ns period.
   always #(brm_pkg::CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
   // Compares one count and reports a mismatch.
   task automatic check(input int seen, input int exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t count %0d expected %0d", $time, seen, exp);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Optionally clears, applies the controls for n clocks and counts the output pulses.
   task automatic run(input logic clr1, input logic [5:0] rate, input logic [1:0] mode, input logic [2:0] ctl,
                      input int n, input int ep, input int eq, input int ec);
      int np, nq, nc;
      np = 0;
      nq = 0;
      nc = 0;
      if (clr1) begin
         clear = 1'h1;
         @(negedge sys_clk);
      end
      {clear, count_en_n, rate_inhibit} = ctl;
      rate_val = rate;
      gate_mode = mode;
      repeat (n) begin
         @(negedge sys_clk);
         // Anything but the idle level counts, so an unknown output shows up as a mismatch.
         np += int'(pulse_n !== 1'h1);
         nq += int'(product_out !== 1'h0);
         nc += int'(carry_n !== 1'h1);
      end
      check(np, ep);
      check(nq, eq);
      check(nc, ec);
      tn++;
      $display("test %0d done", tn);
   endtask
   // A hang is cut short after a cycle ceiling well above the expected run length.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 3000) begin
         err_total++;
         summarize();
      end
   end
   // Main sequence of tests.
   initial begin
      repeat (12) @(negedge sys_clk);
      resetn = 1'h1;
      foreach (rates[i]) begin
         run(1'h1, rates[i], 2'h0, 3'h0, 64, int'(rates[i]), int'(rates[i]), 1);
      end
      run(1'h1, 6'h3f, 2'h1, 3'h0, 64, 63, 64, 1);
      run(1'h1, 6'h3f, 2'h2, 3'h1, 64, 0, 32, 0);
      run(1'h1, 6'h3f, 2'h0, 3'h2, 64, 0, 0, 0);
      run(1'h1, 6'h3f, 2'h0, 3'h5, 8, 0, 0, 0);
      run(1'h0, 6'h20, 2'h0, 3'h0, 10, 5, 5, 0);
      run(1'h1, 6'h20, 2'h0, 3'h0, 63, 31, 31, 0);
      run(1'h1, 6'h20, 2'h0, 3'h0, 32, 16, 16, 0);
      run(1'h0, 6'h01, 2'h0, 3'h0, 32, 1, 1, 1);
      // Four upstream carries in 256 clocks step the counter from state 0 to state 4.
      chain = 1'h1;
      run(1'h1, 6'h3f, 2'h0, 3'h0, 256, 3, 3, 0);
      chain = 1'h0;
      summarize();
   end
endmodule
